// ==== src/ldr_register_bank.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Five-bit brightness code, zero dimmest, ones brightest
// - Brightness code resets to 10111
// - Dimming method comes only from its input
// - Three-bit shutdown mode, resets to 001
// - Force-off bit stops lamp, sets lamp-out flag
// - Pin high plus bit 1 stops lamp
// - Pin low plus bit 0 stops lamp
// - Two seconds without current clears lamp-out flag
// - Cleared lamp-out flag stays cleared until a shutdown
// - Cleared lamp-out flag keeps lamp off
// - Any shutdown, forced or by pin, sets lamp-out flag
// - Overcurrent flag reflects previous chopping period
// - Status bits reset high, writes ignored
// - Identification codes read-only
// - Writes commit at stop, aborted transfers dropped
// - Combined view: brightness, one, lamp-out, overcurrent
// - Register access works during shutdown
module ldr_register_bank #(
    parameter int LAMP_OUT_CYCLES = ldr_pkg::LDR_LAMP_OUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // Write side from the serial protocol engine
    input wire logic wr_strobe_i,
    input wire logic [7:0] wr_cmd_i,
    input wire logic [7:0] wr_data_i,
    input wire logic xfer_commit_i,
    input wire logic xfer_abort_i,
    // Read side
    input wire logic [7:0] rd_cmd_i,
    output logic [7:0] rd_data_o,
    // Lamp side
    input wire logic shutdown_suspend_pin_i,
    input wire logic lamp_current_sense_i,
    input wire logic digital_chop_period_i,
    input wire logic overcurrent_i,
    input wire logic dimming_method_select_i,
    output logic [ldr_pkg::LDR_BRIGHT_W-1:0] brightness_code_o,
    output logic dimming_method_o,
    output logic lamp_enable_o,
    output logic lamp_out_flag_o,
    output logic overcurrent_ok_flag_o
);
    import ldr_pkg::*;

    typedef struct packed {
        logic [LDR_BRIGHT_W-1:0] bright;
        logic [LDR_MODE_W-1:0] mode;
        logic lamp_out;
        logic oc_ok;
        logic oc_seen;
        logic pend_valid;
        logic [7:0] pend_cmd;
        logic [7:0] pend_data;
        logic lamp_en;
        logic dim_method;
        logic [7:0] rd_data;
    } ldr_state_t;

    ldr_state_t st;
    ldr_state_t next_st;
    logic shut;
    logic timeout;

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown decode from mode bits and pin
    always_comb begin
        shut = st.mode[LDR_FORCE_OFF_BIT];
        if (shutdown_suspend_pin_i) begin
            shut = shut | st.mode[LDR_OFF_PIN_HIGH_BIT];
        end else begin
            shut = shut | st.mode[LDR_OFF_PIN_LOW_BIT];
        end
    end

    // Lamp-out timer runs only while the lamp is driven
    ldr_lamp_out_timer #(
        .TIMEOUT_CYCLES(LAMP_OUT_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(st.lamp_en),
        .lamp_current_sense_i(lamp_current_sense_i),
        .timeout_o(timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read decode of a command byte
    function automatic logic [7:0] read_view(input ldr_state_t s, input logic [7:0] cmd);
        logic [7:0] v;
        v = '0;
        if (!cmd[LDR_CMD_HI_BIT]) begin
            case (cmd[1:0])
                LDR_SEL_BRIGHT: v = {LDR_BRIGHT_PAD, s.bright};
                LDR_SEL_MODE: v = {s.lamp_out, s.oc_ok, LDR_MODE_PAD, s.mode};
                LDR_SEL_PART: v = LDR_PART_CODE;
                default: v = LDR_REVISION_CODE;
            endcase
        end else if (!cmd[LDR_CMD_SUB_BIT]) begin
            v = {s.bright, LDR_COMB_ONE, s.lamp_out, s.oc_ok};
        end else if (cmd[0]) begin
            v = LDR_PART_CODE;
        end else begin
            v = LDR_MAKER_CODE;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;
        // Stage write until the transfer is closed cleanly
        if (xfer_abort_i) begin
            next_st.pend_valid = 1'b0;
        end else if (wr_strobe_i) begin
            next_st.pend_valid = 1'b1;
            next_st.pend_cmd = wr_cmd_i;
            next_st.pend_data = wr_data_i;
        end else if (xfer_commit_i && st.pend_valid) begin
            next_st.pend_valid = 1'b0;
            // Commit regardless of lamp state
            if (!st.pend_cmd[LDR_CMD_HI_BIT]) begin
                if (st.pend_cmd[1:0] == LDR_SEL_BRIGHT) begin
                    next_st.bright = st.pend_data[LDR_BRIGHT_W-1:0];
                end else if (st.pend_cmd[1:0] == LDR_SEL_MODE) begin
                    next_st.mode = st.pend_data[LDR_MODE_W-1:0];
                end
            end else if (!st.pend_cmd[LDR_CMD_SUB_BIT]) begin
                next_st.bright = st.pend_data[LDR_COMB_BRIGHT_LSB +: LDR_BRIGHT_W];
            end
            // Status and identification bytes are not written
        end

        // Lamp-out flag: set by any shutdown, forced or by pin, wins over a timeout
        if (shut) begin
            next_st.lamp_out = 1'b1;
        end else if (timeout) begin
            next_st.lamp_out = 1'b0;
        end

        // Overcurrent flag updated at each chopping period boundary
        if (digital_chop_period_i) begin
            next_st.oc_ok = ~(st.oc_seen | overcurrent_i);
            next_st.oc_seen = 1'b0;
        end else if (overcurrent_i) begin
            next_st.oc_seen = 1'b1;
        end

        next_st.lamp_en = ~shut & st.lamp_out;
        next_st.dim_method = dimming_method_select_i;
        next_st.rd_data = read_view(st, rd_cmd_i);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.bright <= LDR_BRIGHT_RST;
            st.mode <= LDR_MODE_RST;
            st.lamp_out <= LDR_LAMP_OUT_RST;
            st.oc_ok <= LDR_OC_OK_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign rd_data_o = st.rd_data;
    assign brightness_code_o = st.bright;
    assign dimming_method_o = st.dim_method;
    assign lamp_enable_o = st.lamp_en;
    assign lamp_out_flag_o = st.lamp_out;
    assign overcurrent_ok_flag_o = st.oc_ok;
endmodule

// ==== src/ldr_pkg.sv ====
package ldr_pkg;
    // Command byte decode
    localparam logic [7:0] LDR_CMD_BRIGHT = 8'h01;
    localparam logic [7:0] LDR_CMD_MODE = 8'h02;
    localparam logic [7:0] LDR_CMD_PART_LO = 8'h03;
    localparam logic [7:0] LDR_CMD_REV = 8'h04;
    localparam logic [7:0] LDR_CMD_COMBINED = 8'h40;
    localparam logic [7:0] LDR_CMD_MAKER = 8'hfe;
    localparam logic [7:0] LDR_CMD_PART_HI = 8'hff;
    localparam int LDR_CMD_HI_BIT = 7;
    localparam int LDR_CMD_SUB_BIT = 6;
    localparam logic [1:0] LDR_SEL_BRIGHT = 2'h1;
    localparam logic [1:0] LDR_SEL_MODE = 2'h2;
    localparam logic [1:0] LDR_SEL_PART = 2'h3;
    localparam logic [1:0] LDR_SEL_REV = 2'h0;

    // Field layout and reset values
    localparam int LDR_BRIGHT_W = 5;
    localparam int LDR_MODE_W = 3;
    localparam logic [LDR_BRIGHT_W-1:0] LDR_BRIGHT_RST = 5'h17;
    localparam logic [LDR_MODE_W-1:0] LDR_MODE_RST = 3'h1;
    localparam logic LDR_LAMP_OUT_RST = 1'h1;
    localparam logic LDR_OC_OK_RST = 1'h1;
    localparam int LDR_FORCE_OFF_BIT = 2;
    localparam int LDR_OFF_PIN_HIGH_BIT = 1;
    localparam int LDR_OFF_PIN_LOW_BIT = 0;
    localparam int LDR_COMB_BRIGHT_LSB = 3;
    localparam logic [2:0] LDR_MODE_PAD = 3'h7;
    localparam logic [2:0] LDR_BRIGHT_PAD = 3'h0;
    localparam logic LDR_COMB_ONE = 1'h1;

    // Identification values, arbitrary
    localparam logic [7:0] LDR_MAKER_CODE = 8'h5a;
    localparam logic [7:0] LDR_PART_CODE = 8'h21;
    localparam logic [7:0] LDR_REVISION_CODE = 8'h01;

    // Lamp-out timeout
    localparam int LDR_CLK_HZ = 20_000_000;
    localparam int LDR_LAMP_OUT_MS = 2000;
    localparam int LDR_LAMP_OUT_CYCLES = (LDR_CLK_HZ / 1000) * LDR_LAMP_OUT_MS;
    localparam int LDR_TIMER_W = 26;
endpackage

// ==== src/ldr_lamp_out_timer.sv ====
`timescale 1ns/1ps
module ldr_lamp_out_timer #(
    parameter int TIMEOUT_CYCLES = ldr_pkg::LDR_LAMP_OUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic lamp_current_sense_i,
    output logic timeout_o
);
    import ldr_pkg::*;

    typedef struct packed {
        logic [LDR_TIMER_W-1:0] count;
        logic timeout;
    } ldr_timer_state_t;

    localparam logic [LDR_TIMER_W-1:0] LAST = LDR_TIMER_W'(TIMEOUT_CYCLES - 1);

    ldr_timer_state_t st;
    ldr_timer_state_t next_st;

    // Count while the lamp runs with no current; any current restarts the wait
    always_comb begin
        next_st = st;
        next_st.timeout = 1'b0;
        if (!run_i || lamp_current_sense_i) begin
            next_st.count = '0;
        end else if (st.count == LAST) begin
            next_st.timeout = 1'b1;
            next_st.count = '0;
        end else begin
            next_st.count = st.count + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign timeout_o = st.timeout;
endmodule

// ==== tb/ldr_rb_monitor.sv ====
`timescale 1ns/1ps
module ldr_rb_monitor #(parameter int LAMP_OUT_CYCLES = 20) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic xfer_commit_i,
    input wire logic [7:0] rd_cmd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic lamp_current_sense_i,
    input wire logic digital_chop_period_i,
    input wire logic overcurrent_i,
    input wire logic [ldr_pkg::LDR_BRIGHT_W-1:0] brightness_code_o,
    input wire logic lamp_enable_o,
    input wire logic lamp_out_flag_o,
    input wire logic overcurrent_ok_flag_o
);
    import ldr_pkg::*;
    logic [31:0] run_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Counts cycles of a running lamp without current
    always_ff @(posedge clk_i) begin
        run_cnt <= (!rstn_i || !lamp_enable_o || lamp_current_sense_i) ? 32'h0 : run_cnt + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Lamp and fault flags
    a_flag_gates_lamp: assert property (!lamp_out_flag_o |=> !lamp_enable_o)
        else $error("lamp runs with lamp-out flag clear");
    a_flag_set_off: assert property ($rose(lamp_out_flag_o) |-> !lamp_enable_o)
        else $error("lamp-out flag set while lamp runs");
    a_timeout_len: assert property ($fell(lamp_out_flag_o) |-> run_cnt >= LAMP_OUT_CYCLES - 1)
        else $error("lamp-out flag cleared too early");
    a_oc_capture: assert property (digital_chop_period_i && overcurrent_i |=> !overcurrent_ok_flag_o)
        else $error("overcurrent not reported");
    a_oc_hold: assert property (!digital_chop_period_i |=> $stable(overcurrent_ok_flag_o))
        else $error("overcurrent flag moved inside a period");
    // Read views and write commit
    a_maker_view: assert property ($past(rstn_i) && $past(rd_cmd_i) == 8'hfe |-> rd_data_o == LDR_MAKER_CODE)
        else $error("maker code view wrong");
    a_comb_view: assert property ($past(rstn_i) && $past(rd_cmd_i[7:6]) == 2'h2 |->
        rd_data_o == {$past(brightness_code_o), 1'h1, $past(lamp_out_flag_o), $past(overcurrent_ok_flag_o)})
        else $error("combined view wrong");
    a_bright_view: assert property ($past(rstn_i) && !$past(rd_cmd_i[7]) && $past(rd_cmd_i[1:0]) == 2'h1 |->
        rd_data_o == {3'h0, $past(brightness_code_o)})
        else $error("brightness view wrong");
    a_commit_gate: assert property ($past(rstn_i) && $changed(brightness_code_o) |-> $past(xfer_commit_i))
        else $error("brightness changed without commit");
    c_oc: cover property (digital_chop_period_i && overcurrent_i);
    c_out: cover property ($fell(lamp_out_flag_o));
    c_set: cover property ($rose(lamp_out_flag_o));
endmodule
bind ldr_register_bank ldr_rb_monitor #(.LAMP_OUT_CYCLES(LAMP_OUT_CYCLES)) u_mon (.clk_i(clk_i), .rstn_i(rstn_i),
    .xfer_commit_i(xfer_commit_i), .rd_cmd_i(rd_cmd_i), .rd_data_o(rd_data_o), .overcurrent_i(overcurrent_i),
    .lamp_current_sense_i(lamp_current_sense_i), .digital_chop_period_i(digital_chop_period_i),
    .brightness_code_o(brightness_code_o), .lamp_enable_o(lamp_enable_o), .lamp_out_flag_o(lamp_out_flag_o),
    .overcurrent_ok_flag_o(overcurrent_ok_flag_o));

// ==== tb/ldr_host_model.sv ====
`timescale 1ns/1ps
module ldr_host_model (
    input wire logic clk_i,
    output logic wr_strobe_o = 1'b0,
    output logic [7:0] wr_cmd_o = 8'h0,
    output logic [7:0] wr_data_o = 8'h0,
    output logic xfer_commit_o = 1'b0,
    output logic xfer_abort_o = 1'b0
);
    // One write-byte transfer, closed by stop or broken early
    task automatic put(input logic [7:0] c, input logic [7:0] d, input logic brk);
        @(posedge clk_i);
        wr_strobe_o <= 1'b1;
        wr_cmd_o <= c;
        wr_data_o <= d;
        @(posedge clk_i);
        wr_strobe_o <= 1'b0;
        wr_cmd_o <= ~c; // Released byte lanes stop showing the byte
        wr_data_o <= ~d;
        xfer_commit_o <= !brk;
        xfer_abort_o <= brk;
        @(posedge clk_i);
        xfer_commit_o <= 1'b0;
        xfer_abort_o <= 1'b0;
    endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
    import ldr_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] rd_cmd_i = 8'h0;
    logic pin = 1'b0;
    logic sense = 1'b1;
    logic chop = 1'b0;
    logic oc = 1'b0;
    logic dim = 1'b0;
    logic wr_strobe, xfer_commit, xfer_abort, dim_o, lamp_en, flag, ok;
    logic [7:0] wr_cmd, wr_data, rd_data;
    logic [4:0] bright;
    int n_errors = 0;
    int n_checks = 0;
    // Rows: command, data, read command, expected read
    logic [31:0] rows [8] = '{32'h010a010a, 32'h80f880ff, 32'h03000321, 32'hfe00fe5a,
        32'h04550401, 32'h020002f8, 32'h41000500, 32'h020706ff};
    always #25 clk_i = ~clk_i;
    ldr_host_model host (.clk_i(clk_i), .wr_strobe_o(wr_strobe), .wr_cmd_o(wr_cmd), .wr_data_o(wr_data),
        .xfer_commit_o(xfer_commit), .xfer_abort_o(xfer_abort));
    ldr_register_bank #(.LAMP_OUT_CYCLES(20)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .wr_strobe_i(wr_strobe),
        .wr_cmd_i(wr_cmd), .wr_data_i(wr_data), .xfer_commit_i(xfer_commit), .xfer_abort_i(xfer_abort),
        .rd_cmd_i(rd_cmd_i), .rd_data_o(rd_data), .shutdown_suspend_pin_i(pin), .lamp_current_sense_i(sense),
        .digital_chop_period_i(chop), .overcurrent_i(oc), .dimming_method_select_i(dim), .brightness_code_o(bright),
        .dimming_method_o(dim_o), .lamp_enable_o(lamp_en), .lamp_out_flag_o(flag), .overcurrent_ok_flag_o(ok));
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Read view after one edge
    task automatic rd(input logic [7:0] c);
        @(posedge clk_i);
        rd_cmd_i <= c;
        tick(1);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Bounded wait for the lamp-out flag
    task automatic wait_flag(input logic v, output int n);
        for (n = 0; n < 60 && flag !== v; n++) tick(1);
        if (n == 60) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // Pin driver
    task automatic set_pin(input logic v);
        @(posedge clk_i);
        pin <= v;
        tick(2);
    endtask
    initial begin
        int i;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        tick(1);
        `CK(bright, 5'h17)
        `CK({flag, ok, lamp_en}, 3'h6)
        rd(8'h02);
        `CK(rd_data, 8'hf9)
        for (i = 0; i < 8; i++) begin
            host.put(rows[i][31:24], rows[i][23:16], 1'b0);
            rd(rows[i][15:8]);
            `CK(rd_data, rows[i][7:0])
        end
        `CK(lamp_en, 1'b0)
        host.put(8'h01, 8'h03, 1'b1);
        rd(8'h01);
        `CK(rd_data, 8'h00)
        dim <= 1'b1;
        host.put(8'h02, 8'h00, 1'b0);
        tick(2);
        `CK({lamp_en, dim_o}, 2'h3)
        sense <= 1'b0;
        wait_flag(1'b0, i);
        `CK(i > 18, 1'b1)
        tick(1);
        `CK(lamp_en, 1'b0)
        sense <= 1'b1;
        host.put(8'h02, 8'h02, 1'b0);
        tick(2);
        `CK({flag, lamp_en}, 2'h0)
        set_pin(1'b1);
        `CK({flag, lamp_en}, 2'h2)
        set_pin(1'b0);
        `CK(lamp_en, 1'b1)
        host.put(8'h02, 8'h01, 1'b0);
        set_pin(1'b1);
        `CK(lamp_en, 1'b1)
        set_pin(1'b0);
        `CK(lamp_en, 1'b0)
        oc <= 1'b1;
        tick(1);
        oc <= 1'b0;
        chop <= 1'b1;
        tick(1);
        chop <= 1'b0;
        `CK(ok, 1'b0)
        tick(1);
        chop <= 1'b1;
        tick(1);
        chop <= 1'b0;
        `CK(ok, 1'b1)
        oc <= 1'b1;
        chop <= 1'b1;
        tick(1);
        oc <= 1'b0;
        chop <= 1'b0;
        `CK(ok, 1'b0)
        // Second reset in mid-run brings every field back
        rstn_i <= 1'b0;
        tick(3);
        `CK({flag, ok, lamp_en, rd_data}, 11'h600)
        rstn_i <= 1'b1;
        rd(8'h02);
        `CK({bright, rd_data}, 13'h17f9)
        rd(8'hff);
        `CK(rd_data, LDR_PART_CODE)
        give_verdict();
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end
endmodule
